//--- verif/e1ei_line_model.sv
// Far-side line model: framer slot strobes, received bits, shot counts.
// Assumes the block's pclk and presetn; strobes recur every 16 cycles.
`default_nettype none

module e1ei_line_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic zero_mode,
    input wire logic [4:0] inject_pulse,
    output logic [4:0] tx_slot_strobe,
    output logic rx_bit_valid,
    output logic rx_bit,
    output var int shot_cnt [5]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] phase_q;

    // Staggered insertion slots, a bit each cycle, pulses counted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 4'h0;
            tx_slot_strobe <= 5'h00;
            rx_bit_valid <= 1'h0;
            rx_bit <= 1'h1;
            shot_cnt <= '{default: 0};
        end else begin
            phase_q <= phase_q + 4'h1;
            for (int i = 0; i < 5; i++) begin
                // Slots
                tx_slot_strobe[i] <= (phase_q == 4'(3 * i));
                shot_cnt[i] <= shot_cnt[i] + int'(inject_pulse[i]);
            end
            rx_bit_valid <= 1'h1;
            rx_bit <= !zero_mode; // Zero runs on demand
        end
    end
endmodule : e1ei_line_model

`default_nettype wire

//--- verif/e1ei_top_monitor.sv
// Port assertions for the error insertion and control block.
// Assumes the single clock pclk and active-low reset presetn.
`default_nettype none

module e1ei_top_monitor #(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [4:0] tx_slot_strobe,
    input wire logic [4:0] inject_pulse,
    input wire logic force_line_silence,
    input wire logic analog_los_pin,
    input wire logic loss_indication_pin,
    input wire logic irq,
    input wire logic irq_n,
    input wire logic irq_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus phases and a held analog loss
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_alos_held;
        analog_los_pin [*6];
    endsequence

    // Bus answer timing and refusal
    AST_PREADY_ZERO_WAIT: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    AST_PREADY_ONE_CYCLE: assert property (pready |=> !pready)
        else $error("pready held too long");
    AST_UNALIGNED_REFUSED: assert property
        ((s_setup ##0 paddr[1:0] != 2'h0) |=> pready && pslverr)
        else $error("unaligned access not refused");
    AST_SLVERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_WRITE_NO_RDATA: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data during write");
    // Insertion pulses
    AST_PULSE_NEEDS_SLOT: assert property (
        inject_pulse != 5'h00 |->
        (inject_pulse & ~$past(tx_slot_strobe)) == 5'h00)
        else $error("insertion pulse outside its slot");
    AST_SILENCE_NO_PULSE: assert property (force_line_silence &&
        $past(force_line_silence) |-> inject_pulse == 5'h00)
        else $error("insertion during line silence");
    // Loss pin and interrupt pin
    AST_ANALOG_LOSS_PIN: assert property (
        s_alos_held |-> loss_indication_pin)
        else $error("analog loss not shown on pin");
    AST_IRQ_PIN_LOW: assert property (
        $rose(irq) && irq_n_oe |-> ##[0:1] (!irq_n || !irq_n_oe))
        else $error("interrupt pin not driven low");
    AST_IRQ_PIN_HIGH: assert property (
        !irq && !$past(irq) && irq_n_oe && $past(irq_n_oe) |-> irq_n)
        else $error("interrupt pin low with no interrupt");
endmodule : e1ei_top_monitor

bind e1ei_top e1ei_top_monitor #(.CNT_W(CNT_W)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_slot_strobe(tx_slot_strobe),
    .inject_pulse(inject_pulse), .force_line_silence(force_line_silence),
    .analog_los_pin(analog_los_pin),
    .loss_indication_pin(loss_indication_pin), .irq(irq), .irq_n(irq_n),
    .irq_n_oe(irq_n_oe)
);

`default_nettype wire

//--- verif/test_e1_error_insert_and_control.sv
// Self-checking bench for the error insertion and control block.
// Assumes the line model in place of the framer; APB master tasks.
`default_nettype none

module test_e1_error_insert_and_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_ERR = {e1ei_pkg::IDX_ERR_INJECT, 2'h0};
    localparam logic [7:0] A_CTL = {e1ei_pkg::IDX_MISC_CTRL, 2'h0};
    localparam logic [7:0] A_STA = {e1ei_pkg::IDX_IRQ_STATUS, 2'h0};
    localparam logic [7:0] A_MSK = {e1ei_pkg::IDX_IRQ_MASK, 2'h0};
    localparam logic [7:0] A_LCV = {e1ei_pkg::IDX_LCV_COUNT, 2'h0};
    localparam logic [7:0] A_CRC = {e1ei_pkg::IDX_CRC_COUNT, 2'h0};
    localparam logic [7:0] A_LST = {e1ei_pkg::IDX_LINE_STATE, 2'h0};
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic rx_frame_sync = 1'h1;
    logic rx_code_violation = 1'h0;
    logic rx_crc_error = 1'h0;
    logic one_second_tick = 1'h0;
    logic analog_los_pin = 1'h0;
    logic zero_mode = 1'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, force_line_silence, rx_bit_valid, rx_bit;
    logic loss_indication_pin, irq, irq_n, irq_n_oe, hdlc_double_speed;
    logic [4:0] tx_slot_strobe, inject_pulse;
    int shot_cnt [5];
    int n_mismatch = 0;
    int n_checks = 0;

    // Clock at 100 MHz
    always #5 pclk = ~pclk;

    e1ei_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_slot_strobe(tx_slot_strobe), .inject_pulse(inject_pulse),
        .force_line_silence(force_line_silence), .rx_bit_valid(rx_bit_valid),
        .rx_bit(rx_bit), .rx_frame_sync(rx_frame_sync),
        .rx_code_violation(rx_code_violation), .rx_crc_error(rx_crc_error),
        .one_second_tick(one_second_tick), .analog_los_pin(analog_los_pin),
        .loss_indication_pin(loss_indication_pin), .irq(irq), .irq_n(irq_n),
        .irq_n_oe(irq_n_oe), .hdlc_double_speed(hdlc_double_speed));
    e1ei_line_model u_line (.pclk(pclk), .presetn(presetn),
        .zero_mode(zero_mode), .inject_pulse(inject_pulse),
        .tx_slot_strobe(tx_slot_strobe), .rx_bit_valid(rx_bit_valid),
        .rx_bit(rx_bit), .shot_cnt(shot_cnt));

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string msg);
        n_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg,
                got, exp);
            n_mismatch++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] exp, input string msg);
        apb(1'h0, a, 32'h0);
        chk(rd & m, exp, msg);
    endtask : rdc

    // Event pulses: 0 line code violation, 1 CRC error, 2 second tick
    task automatic ev(input int k, input int n);
        repeat (n) begin
            @(posedge pclk);
            rx_code_violation <= (k == 0);
            rx_crc_error <= (k == 1);
            one_second_tick <= (k == 2);
            @(posedge pclk);
            {rx_code_violation, rx_crc_error, one_second_tick} <= 3'h0;
        end
        tick(3);
    endtask : ev

    task automatic shots(input int bpv, input int rest);
        tick(40);
        chk(shot_cnt[0], bpv, "bpv shots");
        for (int i = 1; i < 5; i++) begin
            chk(shot_cnt[i], rest, "other shots");
        end
    endtask : shots

    task automatic inject_bpv;
        wr(A_ERR, 32'h00);
        wr(A_ERR, 32'h80);
        tick(40);
    endtask : inject_bpv

    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog far beyond the expected run length
    initial begin
        #(60000 * 10);
        $display("CHECK FAILED at %0t: timeout", $time);
        n_mismatch++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        tick(10);
        presetn <= 1'h1;
        rdc(A_ERR, 32'hFF, 32'h00, "err reset");
        rdc(A_CTL, 32'hFF, 32'h00, "ctl reset");
        rdc(A_MSK, 32'h1F, 32'h00, "mask reset");
        rdc(8'hFC, 32'hFFFFFFFF, 32'h0, "unmapped data");
        chk(er, 32'h1, "unmapped error");
        wr(A_ERR + 8'h01, 32'hFC);
        chk(er, 32'h1, "unaligned error");
        rdc(A_ERR, 32'hFF, 32'h00, "unaligned ignored");
        done("registers");
        wr(A_ERR, 32'hF4);
        shots(1, 1);
        wr(A_ERR, 32'hF4);
        shots(1, 1);
        wr(A_ERR, 32'h00);
        shots(1, 1);
        wr(A_ERR, 32'hF4);
        shots(2, 2);
        wr(A_ERR, 32'h00);
        wr(A_ERR, 32'h88);
        shots(2, 2);
        chk(force_line_silence, 32'h1, "silence on");
        wr(A_ERR, 32'h80);
        shots(3, 2);
        chk(force_line_silence, 32'h0, "silence off");
        done("injection");
        wr(A_ERR, 32'h03);
        zero_mode <= 1'h1;
        tick(40);
        rdc(A_LST, 32'h4, 32'h4, "short run loss");
        chk(loss_indication_pin, 32'h1, "pin on zeros");
        zero_mode <= 1'h0;
        wr(A_ERR, 32'h01);
        tick(10);
        zero_mode <= 1'h1;
        tick(100);
        rdc(A_LST, 32'h4, 32'h0, "long run not yet");
        tick(100);
        rdc(A_LST, 32'h4, 32'h4, "long run loss");
        zero_mode <= 1'h0;
        rx_frame_sync <= 1'h0;
        tick(10);
        chk(loss_indication_pin, 32'h0, "frame loss hidden");
        wr(A_ERR, 32'h00);
        tick(3);
        chk(loss_indication_pin, 32'h1, "frame loss shown");
        rx_frame_sync <= 1'h1;
        analog_los_pin <= 1'h1;
        tick(10);
        chk(loss_indication_pin, 32'h1, "analog loss");
        analog_los_pin <= 1'h0;
        tick(10);
        chk(loss_indication_pin, 32'h0, "loss gone");
        done("loss");
        wr(A_MSK, 32'h10);
        tick(3);
        chk(irq, 32'h1, "irq raised");
        chk(irq_n, 32'h0, "pin low");
        wr(A_CTL, 32'h20);
        tick(3);
        chk(irq, 32'h0, "ack rising");
        chk(irq_n, 32'h1, "pin high");
        rdc(A_STA, 32'h10, 32'h00, "ack cleared");
        inject_bpv();
        chk(irq, 32'h1, "irq again");
        wr(A_CTL, 32'h00);
        tick(3);
        chk(irq, 32'h0, "ack falling");
        inject_bpv();
        wr(A_STA, 32'h10);
        tick(3);
        chk(irq, 32'h0, "write one clears");
        inject_bpv();
        wr(A_MSK, 32'h00);
        tick(3);
        chk(irq, 32'h0, "masked");
        wr(A_CTL, 32'h40);
        tick(3);
        chk(irq_n_oe, 32'h0, "suspend floats");
        wr(A_CTL, 32'h00);
        tick(3);
        chk(irq_n_oe, 32'h1, "suspend off");
        done("interrupts");
        ev(0, 3);
        rdc(A_LCV, 32'hFFFF, 32'h3, "lcv count");
        wr(A_CTL, 32'h10);
        ev(0, 2);
        rdc(A_LCV, 32'hFFFF, 32'h0, "lcv held clear");
        wr(A_CTL, 32'h04);
        rx_frame_sync <= 1'h0;
        ev(0, 2);
        rdc(A_LCV, 32'hFFFF, 32'h0, "lcv paused");
        rx_frame_sync <= 1'h1;
        ev(0, 1);
        rdc(A_LCV, 32'hFFFF, 32'h1, "lcv resumed");
        wr(A_CTL, 32'h08);
        ev(0, 2);
        rdc(A_LCV, 32'hFFFF, 32'h1, "lcv sampled old");
        ev(2, 1);
        rdc(A_LCV, 32'hFFFF, 32'h3, "lcv sampled new");
        wr(A_CTL, 32'h00);
        ev(1, 1);
        rdc(A_CRC, 32'hFFFF, 32'h1, "crc count");
        done("counters");
        wr(A_CTL, 32'h01);
        tick(2);
        chk(hdlc_double_speed, 32'h1, "double speed");
        wr(A_ERR, 32'h03);
        wr(A_MSK, 32'h1F);
        wr(A_CTL, 32'h80);
        rdc(A_ERR, 32'hFF, 32'h00, "soft reset err");
        rdc(A_MSK, 32'h1F, 32'h00, "soft reset mask");
        rdc(A_CTL, 32'hFF, 32'h00, "soft reset ctl");
        chk(hdlc_double_speed, 32'h0, "soft reset speed");
        done("control");
        report_and_stop();
    end
endmodule : test_e1_error_insert_and_control

`default_nettype wire

//--- verilog/e1ei_pkg.sv
// Constants for the E1 transmit error insertion and control block.
// Assumes one 100 MHz APB clock and an active-low asynchronous reset.
`default_nettype none

package e1ei_pkg;

    // Register indices; the APB byte address is four times the index
    localparam logic [5:0] IDX_ERR_INJECT = 6'h19;
    localparam logic [5:0] IDX_MISC_CTRL = 6'h1A;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h21;
    localparam logic [5:0] IDX_LCV_COUNT = 6'h22;
    localparam logic [5:0] IDX_CRC_COUNT = 6'h23;
    localparam logic [5:0] IDX_LINE_STATE = 6'h24;

    // Reset values
    localparam logic [7:0] ERR_INJECT_RST = 8'h00;
    localparam logic [7:0] MISC_CTRL_RST = 8'h00;
    localparam logic [4:0] IRQ_MASK_RST = 5'h00;

    // Bits of transmit_error_injection
    localparam int EI_BPV = 7;
    localparam int EI_CRC = 6;
    localparam int EI_FAS = 5;
    localparam int EI_NFAS = 4;
    localparam int EI_SILENCE = 3;
    localparam int EI_PAYLOAD = 2;
    localparam int EI_SHORT_THR = 1;
    localparam int EI_LOSS_SEL = 0;

    // Bits of device_misc_control
    localparam int MC_RESET = 7;
    localparam int MC_SUSPEND = 6;
    localparam int MC_ACK = 5;
    localparam int MC_CNT_CLEAR = 4;
    localparam int MC_SAMPLE = 3;
    localparam int MC_OOF_PAUSE = 2;
    localparam int MC_DOUBLE = 0;

    // Single-shot insertion channels, in pulse-vector order
    localparam int NUM_INJ = 5;
    localparam int INJ_BPV = 0;
    localparam int INJ_CRC = 1;
    localparam int INJ_FAS = 2;
    localparam int INJ_NFAS = 3;
    localparam int INJ_PAYLOAD = 4;
    localparam int INJ_BIT [NUM_INJ] = '{EI_BPV, EI_CRC, EI_FAS, EI_NFAS,
        EI_PAYLOAD};

    // Interrupt status bits
    localparam int NUM_IRQ = 5;
    localparam int IRQ_LOSS_CHG = 0;
    localparam int IRQ_SYNC_CHG = 1;
    localparam int IRQ_LCV = 2;
    localparam int IRQ_CRC = 3;
    localparam int IRQ_INJ_DONE = 4;

    // Digital loss-of-signal zero-run thresholds
    localparam int ZRUN_W = 9;
    localparam logic [ZRUN_W-1:0] ZRUN_SHORT = 9'h020;
    localparam logic [ZRUN_W-1:0] ZRUN_LONG = 9'h0C0;
    localparam logic [ZRUN_W-1:0] ZRUN_MAX = 9'h100;

endpackage : e1ei_pkg

`default_nettype wire

//--- verilog/e1ei_shot.sv
// Single-shot error insertion: holds one armed request per channel and
// releases it as a one-cycle pulse in the cycle after the next transmit slot allowed.
// Assumes arm and apply come from logic on the same clock.
`default_nettype none

module e1ei_shot #(
    parameter int N = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    e1ei_shot_if.shot sif
);

    logic [N-1:0] pend_q;
    logic [N-1:0] pend_d;
    logic [N-1:0] fire_q;
    logic [N-1:0] fire_now;

    // One request per rising change, released once at the slot
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ch
            assign fire_now[i] = pend_q[i] & sif.apply[i];
            // A new arm in the firing cycle stays pending
            assign pend_d[i] = (pend_q[i] & ~fire_now[i]) | sif.arm[i];
        end
    endgenerate

    // Pending and pulse registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= '0;
            fire_q <= '0;
        end else if (sif.clr) begin
            pend_q <= '0;
            fire_q <= '0;
        end else begin
            pend_q <= pend_d;
            fire_q <= fire_now;
        end
    end

    assign sif.fire = fire_q;
    assign sif.pending = pend_q;

endmodule : e1ei_shot

`default_nettype wire

//--- verilog/e1ei_shot_if.sv
// Interface between the register bank and the single-shot insertion unit.
// Assumes both ends run on the same APB clock.
`default_nettype none

interface e1ei_shot_if #(
    parameter int N = 5
);
    logic [N-1:0] arm;
    logic [N-1:0] apply;
    logic [N-1:0] fire;
    logic [N-1:0] pending;
    logic clr;

    modport bank (output arm, output apply, output clr, input fire,
        input pending);
    modport shot (input arm, input apply, input clr, output fire,
        output pending);
endinterface : e1ei_shot_if

`default_nettype wire

//--- verilog/e1ei_top.sv
// E1 transmit error insertion and device control register bank on APB.
// Assumes the transmit framer strobes each insertion slot for one cycle,
// receive status inputs share pclk, and the analog loss pin is async.
//
// Our own choice: the APB interface to the registers.
`default_nettype none

module e1ei_top #(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [e1ei_pkg::NUM_INJ-1:0] tx_slot_strobe,
    output logic [e1ei_pkg::NUM_INJ-1:0] inject_pulse,
    output logic force_line_silence,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic rx_frame_sync,
    input wire logic rx_code_violation,
    input wire logic rx_crc_error,
    input wire logic one_second_tick,
    input wire logic analog_los_pin,
    output logic loss_indication_pin,
    output logic irq,
    output logic irq_n,
    output logic irq_n_oe,
    output logic hdlc_double_speed
);

    localparam int NI = e1ei_pkg::NUM_INJ;
    localparam int NQ = e1ei_pkg::NUM_IRQ;
    localparam int ZW = e1ei_pkg::ZRUN_W;

    // Bus registers
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_mux;

    // Software registers
    logic [7:0] err_q;
    logic [7:0] ctrl_q;
    logic [NQ-1:0] mask_q;
    logic [NQ-1:0] stat_q;
    logic [NQ-1:0] stat_d;

    // Line state
    logic [2:0] alos_sync_q;
    logic alos_q;
    logic [ZW-1:0] zrun_q;
    logic dig_los;
    logic loss_q;
    logic loss_d;
    logic sync_prev_q;

    // Interrupt registers
    logic irq_q;
    logic irq_n_q;
    logic irq_n_oe_q;

    // Counters: index 0 line code violations, 1 CRC errors
    logic [CNT_W-1:0] cnt_live_q [2];
    logic [CNT_W-1:0] cnt_show_q [2];
    logic [1:0] cnt_inc;

    e1ei_shot_if #(.N(NI)) sif ();

    // APB phase and address decode
    wire setup = psel & ~penable;
    wire access = psel & penable & pready_q;
    wire wr = access & pwrite;
    wire [5:0] idx = paddr[7:2];
    wire aligned = (paddr[1:0] == 2'h0);

    // Register hits
    wire hit_err = aligned & (idx == e1ei_pkg::IDX_ERR_INJECT);
    wire hit_ctrl = aligned & (idx == e1ei_pkg::IDX_MISC_CTRL);
    wire hit_stat = aligned & (idx == e1ei_pkg::IDX_IRQ_STATUS);
    wire hit_mask = aligned & (idx == e1ei_pkg::IDX_IRQ_MASK);
    wire hit_lcv = aligned & (idx == e1ei_pkg::IDX_LCV_COUNT);
    wire hit_crc = aligned & (idx == e1ei_pkg::IDX_CRC_COUNT);
    wire hit_state = aligned & (idx == e1ei_pkg::IDX_LINE_STATE);
    wire hit_any = hit_err | hit_ctrl | hit_stat | hit_mask | hit_lcv
        | hit_crc | hit_state;

    // Write strobes
    wire wr_err = wr & hit_err;
    wire wr_ctrl = wr & hit_ctrl;
    wire wr_stat = wr & hit_stat;
    wire wr_mask = wr & hit_mask;

    // Control decode
    wire [7:0] wbyte = pwdata[7:0];

    // Control bit edges
    wire soft_rst = wr_ctrl & wbyte[e1ei_pkg::MC_RESET]
        & ~ctrl_q[e1ei_pkg::MC_RESET];
    wire ack_toggle = wr_ctrl & (wbyte[e1ei_pkg::MC_ACK]
        ^ ctrl_q[e1ei_pkg::MC_ACK]);

    // Level controls
    wire suspend = ctrl_q[e1ei_pkg::MC_SUSPEND];
    wire cnt_clear = ctrl_q[e1ei_pkg::MC_CNT_CLEAR];
    wire sample = ctrl_q[e1ei_pkg::MC_SAMPLE];
    wire oof_pause = ctrl_q[e1ei_pkg::MC_OOF_PAUSE];
    wire silence = err_q[e1ei_pkg::EI_SILENCE];

    // Arm on a written rising edge of each single-shot bit
    genvar g;
    generate
        for (g = 0; g < NI; g++) begin : g_arm
            assign sif.arm[g] = wr_err & wbyte[e1ei_pkg::INJ_BIT[g]]
                & ~err_q[e1ei_pkg::INJ_BIT[g]];
        end
    endgenerate

    // Slots: BPV, CRC, FAS, NFAS bit two, payload; held off in silence
    assign sif.apply = tx_slot_strobe & {NI{~silence}};
    assign sif.clr = soft_rst;

    e1ei_shot #(.N(NI)) u_shot (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif)
    );

    // Each pulse marks one error at its slot
    assign inject_pulse = sif.fire;
    // Inversion of NFAS bit two and payload error ride the same pulses

    // APB answer: zero wait states, error on unmapped or unaligned address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~hit_any;
            prdata_q <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Read multiplexer; unused upper bits read as zero
    wire [31:0] rd_err = {24'h000000, err_q};
    wire [31:0] rd_ctrl = {24'h000000, ctrl_q};
    wire [31:0] rd_stat = {{(32-NQ){1'b0}}, stat_q};
    wire [31:0] rd_mask = {{(32-NQ){1'b0}}, mask_q};
    wire [31:0] rd_lcv = {{(32-CNT_W){1'b0}}, cnt_show_q[0]};
    wire [31:0] rd_crc = {{(32-CNT_W){1'b0}}, cnt_show_q[1]};
    // Line state word
    wire [31:0] rd_state = {{(24-NI){1'b0}}, sif.pending, 4'h0,
        alos_q, dig_los, rx_frame_sync, loss_q};
    assign rd_mux = ({32{hit_err}} & rd_err)
        | ({32{hit_ctrl}} & rd_ctrl)
        | ({32{hit_stat}} & rd_stat)
        | ({32{hit_mask}} & rd_mask)
        | ({32{hit_lcv}} & rd_lcv)
        | ({32{hit_crc}} & rd_crc)
        | ({32{hit_state}} & rd_state);

    // Software registers; a rising reset bit returns all to defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= e1ei_pkg::ERR_INJECT_RST;
            ctrl_q <= e1ei_pkg::MISC_CTRL_RST;
            mask_q <= e1ei_pkg::IRQ_MASK_RST;
        end else if (soft_rst) begin
            err_q <= e1ei_pkg::ERR_INJECT_RST;
            ctrl_q <= e1ei_pkg::MISC_CTRL_RST;
            mask_q <= e1ei_pkg::IRQ_MASK_RST;
        end else begin
            if (wr_err) begin
                err_q <= wbyte;
            end
            if (wr_ctrl) begin
                ctrl_q <= wbyte; // Reserved bit stored as written
            end
            if (wr_mask) begin
                mask_q <= pwdata[NQ-1:0];
            end
        end
    end

    // Level outputs taken directly from register bits
    assign force_line_silence = silence;
    assign hdlc_double_speed = ctrl_q[e1ei_pkg::MC_DOUBLE];

    // Analog loss pin: three stages, change taken when stages two and
    // three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alos_sync_q <= 3'h0;
            alos_q <= 1'b0;
        end else begin
            alos_sync_q <= {alos_sync_q[1:0], analog_los_pin};
            if (alos_sync_q[1] == alos_sync_q[2]) begin
                alos_q <= alos_sync_q[2];
            end
        end
    end

    // Digital loss of signal: run of received zeros against threshold
    wire [ZW-1:0] zthr = err_q[e1ei_pkg::EI_SHORT_THR]
        ? e1ei_pkg::ZRUN_SHORT : e1ei_pkg::ZRUN_LONG;
    assign dig_los = (zrun_q >= zthr);
    wire zrun_sat = (zrun_q == e1ei_pkg::ZRUN_MAX);

    // Zero run counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zrun_q <= '0;
        end else if (soft_rst) begin
            zrun_q <= '0;
        end else if (rx_bit_valid) begin
            if (rx_bit) begin
                zrun_q <= '0;
            end else if (!zrun_sat) begin
                zrun_q <= zrun_q + ZW'(1);
            end
        end
    end

    // Loss indication: signal loss, plus frame loss when select is low
    wire los_any = alos_q | dig_los;
    assign loss_d = los_any | (~err_q[e1ei_pkg::EI_LOSS_SEL]
        & ~rx_frame_sync);

    // Loss pin register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loss_q <= 1'b0;
            sync_prev_q <= 1'b1;
        end else begin
            loss_q <= loss_d;
            sync_prev_q <= rx_frame_sync;
        end
    end

    assign loss_indication_pin = loss_q;

    // Status counters: violation count pauses out of frame if asked
    assign cnt_inc[0] = rx_code_violation
        & ~(oof_pause & ~rx_frame_sync);
    assign cnt_inc[1] = rx_crc_error;

    generate
        for (g = 0; g < 2; g++) begin : g_cnt
            // Live count; clear bit holds it at zero
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_live_q[g] <= '0;
                end else if (soft_rst || cnt_clear) begin
                    cnt_live_q[g] <= '0;
                end else if (cnt_inc[g]) begin
                    cnt_live_q[g] <= cnt_live_q[g] + CNT_W'(1);
                end
            end

            // Visible count: follows live, or only on the second tick
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_show_q[g] <= '0;
                end else if (soft_rst || cnt_clear) begin
                    cnt_show_q[g] <= '0;
                end else if (!sample || one_second_tick) begin
                    cnt_show_q[g] <= cnt_live_q[g];
                end
            end
        end
    endgenerate

    // Interrupt sources, ignored while suspended
    wire [NQ-1:0] ev_raw = {|sif.fire, cnt_inc[1], cnt_inc[0],
        rx_frame_sync ^ sync_prev_q, loss_d ^ loss_q};
    wire [NQ-1:0] ev = ev_raw & {NQ{~suspend}};
    wire [NQ-1:0] w1c = wr_stat ? pwdata[NQ-1:0] : '0;
    wire [NQ-1:0] ack_clr = {NQ{ack_toggle}};

    // A new event wins over a clear in the same cycle
    assign stat_d = (stat_q & ~w1c & ~ack_clr) | ev;
    wire irq_on = |(stat_d & mask_q);

    // Status and pin registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
            irq_q <= 1'b0;
            irq_n_q <= 1'b1;
            irq_n_oe_q <= 1'b1;
        end else if (soft_rst) begin
            stat_q <= '0;
            irq_q <= 1'b0;
            irq_n_q <= 1'b1;
            irq_n_oe_q <= 1'b1;
        end else begin
            stat_q <= stat_d;
            irq_q <= irq_on;
            irq_n_q <= ~irq_on;
            irq_n_oe_q <= ~(wr_ctrl ? wbyte[e1ei_pkg::MC_SUSPEND]
                : suspend);
        end
    end

    // Interrupt outputs
    assign irq = irq_q;
    assign irq_n = irq_n_q;
    assign irq_n_oe = irq_n_oe_q;

    // APB outputs
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;

endmodule : e1ei_top

`default_nettype wire
